// ==== logic/fec_pkg.sv ====
// Behaviour
// - array holds main, vector and protect bytes
// - erased bits read one, programmed bits zero
// - page erase clears all 64 bytes
// - high voltage only after proper setup sequence
// - high voltage bit drives pump and array
// - mass bit picks mass or page erase
// - erase and program never both set
// - erase bit selects erase operation
// - program bit selects byte programming
// - last page refuses page erase
// - mass erase blocked unless protect reads all ones
package fec_pkg;

  // register word offsets on the bus (byte addresses)
  localparam logic [7:0] FEC_OFS_CTRL = 8'h00;   // flash_control_reg
  localparam logic [7:0] FEC_OFS_BPR  = 8'h04;   // block_protect_reg view
  localparam logic [7:0] FEC_OFS_ADDR = 8'h08;   // array address pointer
  localparam logic [7:0] FEC_OFS_DATA = 8'h0c;   // array data window
  localparam logic [7:0] FEC_OFS_STAT = 8'h10;   // sequence status

  // control register field positions
  localparam int FEC_CTRL_PGM  = 0;
  localparam int FEC_CTRL_WIPE = 1;
  localparam int FEC_CTRL_MASS = 2;
  localparam int FEC_CTRL_HV   = 3;

  // status register field positions
  localparam int FEC_ST_ARMED   = 0;
  localparam int FEC_ST_SETUP   = 1;
  localparam int FEC_ST_HV      = 2;
  localparam int FEC_ST_SWEEP   = 3;
  localparam int FEC_ST_ERASED  = 4;
  localparam int FEC_ST_REFUSED = 5;

  // reset values
  localparam logic [15:0] FEC_ADDR_RST = 16'hc000;
  localparam logic [7:0]  FEC_BPR_RST  = 8'h00;  // protected until read

  // array layout
  localparam int          FEC_AW        = 14;
  localparam logic [15:0] FEC_MAIN_END  = 16'hfdff;  // 15,872 bytes from c000
  localparam logic [15:0] FEC_BPR_LOC   = 16'hff7e;
  localparam logic [15:0] FEC_VEC_START = 16'hffdc;  // 36 vector bytes
  localparam logic [7:0]  FEC_ERASED    = 8'hff;
  localparam logic [7:0]  FEC_NO_PROT   = 8'hff;
  localparam logic [5:0]  FEC_PAGE_LAST = 6'h3f;

  // timing
  localparam int CLK_PERIOD_NS  = 5;
  localparam int SETUP_DELAY_US = 10;
  localparam int PAGE_HOLD_MS   = 1;
  localparam int FULL_WIPE_MS   = 4;
  localparam int SETUP_CYC =
    (SETUP_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_HOLD_CYC  = PAGE_HOLD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FULL_WIPE_CYC  = FULL_WIPE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FEC_CNT_W      = 20;

  typedef struct packed {
    logic hv;
    logic mass;
    logic wipe;
    logic program_select;
  } fec_ctrl_t;

  typedef enum logic [2:0] {
    FEC_IDLE, FEC_SELECTED, FEC_PROT_READ, FEC_ARMED, FEC_ACTIVE
  } fec_state_t;

endpackage

// ==== logic/fec_mem.sv ====
`timescale 1ns/1ps
module fec_mem
  import fec_pkg::*;
(
  input  wire logic              clk,      // system clock
  input  wire logic              we,       // byte write enable
  input  wire logic [FEC_AW-1:0] addr,     // byte index
  input  wire logic [7:0]        wdata,    // write byte
  output logic      [7:0]        rdata_r   // registered read byte
);

  logic [7:0] cells [0:(1<<FEC_AW)-1];

  // cells kept in a plain clocked process so they can be preloaded from outside
  always @(posedge clk) begin
    if (we) begin
      cells[addr] <= wdata;
    end
  end

  // single port, read-before-write so a program step sees the old byte
  always_ff @(posedge clk) begin
    rdata_r <= cells[addr];
  end

endmodule

// ==== logic/fec_top.sv ====
// Added by the designer: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module fec_top
  import fec_pkg::*;
#(
  parameter int PAGE_HOLD = PAGE_HOLD_CYC,   // page erase hold cycles
  parameter int MASS_HOLD = FULL_WIPE_CYC    // mass erase hold cycles
)(
  input  wire logic        sys_clk,     // 200 MHz clock
  input  wire logic        reset_n,     // async reset, active low
  input  wire logic        wb_cyc_i,    // bus cycle
  input  wire logic        wb_stb_i,    // strobe
  input  wire logic        wb_we_i,     // write
  input  wire logic [7:0]  wb_adr_i,    // byte address
  input  wire logic [3:0]  wb_sel_i,    // byte lanes
  input  wire logic [31:0] wb_dat_i,    // write data
  output logic      [31:0] wb_dat_o,    // read data
  output logic             wb_ack_o,    // acknowledge
  output logic             pump_on      // charge pump and array high voltage
);

  // reset release through two flops
  logic rst_meta_r;
  logic rst_n_r;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // array byte exists only in main, protect and vector ranges
  function automatic logic arr_valid(input logic [15:0] a);
    return (a[15:14] == 2'b11) &&
           (a <= FEC_MAIN_END || a == FEC_BPR_LOC || a >= FEC_VEC_START);
  endfunction

  // protected from start address up to the top of the array
  function automatic logic arr_prot(input logic [7:0] bpr, input logic [15:0] a);
    return (bpr != FEC_NO_PROT) && (a >= {2'b11, bpr, 6'h00});
  endfunction

  // true when the bus word address selects the given register
  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr[7:2] == ofs[7:2];
  endfunction

  fec_ctrl_t   ctrl_r;
  fec_state_t  state_r;
  logic [15:0] addr_r;
  logic [15:0] tgt_r;
  logic [7:0]  bpr_r;
  logic [FEC_CNT_W-1:0] cnt_r;
  logic        sweep_r;
  logic [FEC_AW-1:0] sweep_addr_r;
  logic [FEC_AW-1:0] sweep_end_r;
  logic        wiped_r;
  logic        erased_r;
  logic        refused_r;
  logic        pend_r;
  logic        ack_r;
  logic [31:0] dat_r;
  logic        pump_r;

  logic [7:0]        mem_rd;
  logic [7:0]        mem_wd;
  logic [FEC_AW-1:0] mem_addr;
  logic              mem_we;

  // bus request handshake: taken, then answered on the next edge
  logic req;
  logic acc;
  logic acc_wr;
  logic acc_rd;
  assign req    = wb_cyc_i & wb_stb_i & ~pend_r & ~ack_r & ~sweep_r;
  assign acc    = pend_r;
  assign acc_wr = acc & wb_we_i;
  assign acc_rd = acc & ~wb_we_i;

  logic ctrl_wr;
  logic bpr_rd;
  logic data_wr;
  logic mapped;
  assign ctrl_wr = acc_wr & wb_sel_i[0] & reg_hit(wb_adr_i, FEC_OFS_CTRL);
  assign bpr_rd  = acc_rd & reg_hit(wb_adr_i, FEC_OFS_BPR);
  assign data_wr = acc_wr & wb_sel_i[0] & reg_hit(wb_adr_i, FEC_OFS_DATA);
  assign mapped  = reg_hit(wb_adr_i, FEC_OFS_CTRL) | reg_hit(wb_adr_i, FEC_OFS_BPR) |
                   reg_hit(wb_adr_i, FEC_OFS_ADDR) | reg_hit(wb_adr_i, FEC_OFS_DATA) |
                   reg_hit(wb_adr_i, FEC_OFS_STAT);

  // proposed control value after a write, with the select interlock
  fec_ctrl_t wr_ctrl;
  fec_ctrl_t nxt_mode;
  always_comb begin
    wr_ctrl  = fec_ctrl_t'(wb_dat_i[3:0]);
    nxt_mode = ctrl_r;
    nxt_mode.mass = wr_ctrl.mass;
    if (!(wr_ctrl.wipe && wr_ctrl.program_select)) begin
      nxt_mode.wipe = wr_ctrl.wipe;
      nxt_mode.program_select  = wr_ctrl.program_select;
    end
  end

  // conditions that forbid raising high voltage
  logic setup_done;
  logic hv_block;
  logic hv_ok;
  assign setup_done = (state_r == FEC_ARMED) && (cnt_r >= FEC_CNT_W'(SETUP_CYC));
  always_comb begin
    hv_block = 1'b0;
    if (nxt_mode.wipe && nxt_mode.mass) begin
      hv_block = (bpr_r != FEC_NO_PROT);
    end else if (nxt_mode.wipe) begin
      hv_block = arr_prot(bpr_r, tgt_r) ||
                 (tgt_r[15:6] == {4'hf, FEC_PAGE_LAST});
    end else begin
      hv_block = arr_prot(bpr_r, tgt_r);
    end
  end
  // only after select, protect read, arming write and setup wait
  assign hv_ok = (nxt_mode.wipe | nxt_mode.program_select) & setup_done & ~hv_block;

  // control register; high voltage clears freely, sets only when allowed
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_r <= '0;
    end else if (ctrl_wr) begin
      ctrl_r.mass <= nxt_mode.mass;
      ctrl_r.wipe <= nxt_mode.wipe;
      ctrl_r.program_select  <= nxt_mode.program_select;
      if (!wr_ctrl.hv) begin
        ctrl_r.hv <= 1'b0;
      end else if (!ctrl_r.hv) begin
        ctrl_r.hv <= hv_ok;
      end
    end
  end

  // refused high voltage attempts, sticky; a new refusal beats the clear
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      refused_r <= 1'b0;
    end else if (ctrl_wr && wr_ctrl.hv && !ctrl_r.hv && !hv_ok) begin
      refused_r <= 1'b1;
    end else if (acc_wr && wb_sel_i[0] && reg_hit(wb_adr_i, FEC_OFS_STAT) &&
                 wb_dat_i[FEC_ST_REFUSED]) begin
      refused_r <= 1'b0;
    end
  end

  // sequence tracking; steps may be separated by unrelated accesses
  logic mode_any;
  assign mode_any = ctrl_r.wipe | ctrl_r.program_select;
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= FEC_IDLE;
    end else begin
      unique case (state_r)
        FEC_IDLE: begin
          if (mode_any) begin
            state_r <= FEC_SELECTED;
          end
        end
        FEC_SELECTED: begin
          if (!mode_any) begin
            state_r <= FEC_IDLE;
          end else if (bpr_rd) begin
            state_r <= FEC_PROT_READ;
          end
        end
        FEC_PROT_READ: begin
          if (!mode_any) begin
            state_r <= FEC_IDLE;
          end else if (data_wr) begin
            state_r <= FEC_ARMED;
          end
        end
        FEC_ARMED: begin
          if (ctrl_r.hv) begin
            state_r <= FEC_ACTIVE;
          end else if (!mode_any) begin
            state_r <= FEC_IDLE;
          end
        end
        FEC_ACTIVE: begin
          if (!ctrl_r.hv) begin
            state_r <= FEC_IDLE;
          end
        end
      endcase
    end
  end

  // arming write latches the target; secured monitor may aim at the protect byte
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tgt_r <= FEC_ADDR_RST;
    end else if (state_r == FEC_PROT_READ && data_wr && mode_any) begin
      tgt_r <= addr_r;
    end
  end

  // one counter serves the setup wait and the erase hold, saturating
  logic cnt_clear;
  assign cnt_clear = (state_r == FEC_PROT_READ) || (state_r == FEC_ARMED && ctrl_r.hv);
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cnt_r <= '0;
    end else if (cnt_clear) begin
      cnt_r <= '0;
    end else if ((state_r == FEC_ARMED || state_r == FEC_ACTIVE) && ~&cnt_r) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // erase fires once the hold is met while erase is still selected
  logic hold_met;
  logic sweep_go;
  assign hold_met = ctrl_r.mass ? (cnt_r >= FEC_CNT_W'(MASS_HOLD))
                                : (cnt_r >= FEC_CNT_W'(PAGE_HOLD));
  assign sweep_go = (state_r == FEC_ACTIVE) && ctrl_r.hv && ctrl_r.wipe && hold_met &&
                    !wiped_r && !sweep_r && !pend_r && !req;  // no take in the start cycle

  // erase sweep writes the erased pattern one byte per cycle
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sweep_r      <= 1'b0;
      sweep_addr_r <= '0;
      sweep_end_r  <= '0;
      wiped_r      <= 1'b0;
    end else if (sweep_go) begin
      sweep_r <= 1'b1;
      wiped_r <= 1'b1;
      if (ctrl_r.mass) begin
        sweep_addr_r <= '0;
        sweep_end_r  <= '1;
      end else begin
        sweep_addr_r <= {tgt_r[FEC_AW-1:6], 6'h00};
        sweep_end_r  <= {tgt_r[FEC_AW-1:6], 6'h3f};
      end
    end else if (sweep_r) begin
      sweep_addr_r <= sweep_addr_r + 1'b1;
      if (sweep_addr_r == sweep_end_r) begin
        sweep_r <= 1'b0;
      end
    end else if (state_r != FEC_ACTIVE) begin
      wiped_r <= 1'b0;
    end
  end

  // erase completion flag, sticky; completion beats the clear
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      erased_r <= 1'b0;
    end else if (sweep_r && sweep_addr_r == sweep_end_r) begin
      erased_r <= 1'b1;
    end else if (acc_wr && wb_sel_i[0] && reg_hit(wb_adr_i, FEC_OFS_STAT) &&
                 wb_dat_i[FEC_ST_ERASED]) begin
      erased_r <= 1'b0;
    end
  end

  // array pointer register
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      addr_r <= FEC_ADDR_RST;
    end else if (acc_wr && reg_hit(wb_adr_i, FEC_OFS_ADDR)) begin
      if (wb_sel_i[0]) begin
        addr_r[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        addr_r[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // protect byte is captured from the array when software reads it
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      bpr_r <= FEC_BPR_RST;
    end else if (bpr_rd) begin
      bpr_r <= mem_rd;
    end
  end

  // programming can only clear bits, so erased ones stay one until written zero
  logic prog_wr;
  assign prog_wr = data_wr && ctrl_r.program_select && ctrl_r.hv && state_r == FEC_ACTIVE &&
                   arr_valid(addr_r) && !arr_prot(bpr_r, addr_r);
  always_comb begin
    if (sweep_r) begin
      mem_addr = sweep_addr_r;
    end else if (reg_hit(wb_adr_i, FEC_OFS_BPR)) begin
      mem_addr = FEC_BPR_LOC[FEC_AW-1:0];
    end else begin
      mem_addr = addr_r[FEC_AW-1:0];
    end
    mem_we = sweep_r | prog_wr;
    mem_wd = sweep_r ? FEC_ERASED : (mem_rd & wb_dat_i[7:0]);
  end

  // array storage, full 16K index space; unused holes are never exposed
  fec_mem u_mem (
    .clk     (sys_clk),
    .we      (mem_we),
    .addr    (mem_addr),
    .wdata   (mem_wd),
    .rdata_r (mem_rd)
  );

  // read data mux for the answer cycle
  logic [31:0] rd_word;
  always_comb begin
    rd_word = '0;
    if (reg_hit(wb_adr_i, FEC_OFS_CTRL)) begin
      rd_word[3:0] = ctrl_r;
    end else if (reg_hit(wb_adr_i, FEC_OFS_BPR)) begin
      rd_word[7:0] = mem_rd;
    end else if (reg_hit(wb_adr_i, FEC_OFS_ADDR)) begin
      rd_word[15:0] = addr_r;
    end else if (reg_hit(wb_adr_i, FEC_OFS_DATA)) begin
      rd_word[7:0] = arr_valid(addr_r) ? mem_rd : 8'h00;
    end else if (mapped) begin
      rd_word[FEC_ST_ARMED]   = (state_r == FEC_ARMED);
      rd_word[FEC_ST_SETUP]   = setup_done;
      rd_word[FEC_ST_HV]      = ctrl_r.hv;
      rd_word[FEC_ST_SWEEP]   = sweep_r;
      rd_word[FEC_ST_ERASED]  = erased_r;
      rd_word[FEC_ST_REFUSED] = refused_r;
    end
  end

  // bus slave: take on one edge, ack on the next, unmapped reads zero
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pend_r <= 1'b0;
      ack_r  <= 1'b0;
      dat_r  <= '0;
    end else begin
      pend_r <= req;
      ack_r  <= acc;
      if (acc_rd) begin
        dat_r <= rd_word;
      end
    end
  end

  // pump follows the high voltage bit one cycle later
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pump_r <= 1'b0;
    end else begin
      pump_r <= ctrl_r.hv;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign pump_on  = pump_r;

endmodule

// ==== tb/fec_chk.sv ====
`timescale 1ns/1ps
module fec_chk
  import fec_pkg::*;
#(
  parameter int PAGE_HOLD = 50,  // page hold cycles
  parameter int MASS_HOLD = 100  // mass hold cycles
)(
  input wire logic        sys_clk,   // clock
  input wire logic        reset_n,   // reset, active low
  input wire logic        wb_cyc_i,  // cycle
  input wire logic        wb_stb_i,  // strobe
  input wire logic        wb_we_i,   // write
  input wire logic [7:0]  wb_adr_i,  // address
  input wire logic [3:0]  wb_sel_i,  // lanes
  input wire logic [31:0] wb_dat_i,  // write data
  input wire logic [31:0] wb_dat_o,  // read data
  input wire logic        wb_ack_o,  // acknowledge
  input wire logic        pump_on    // charge pump
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // acknowledged accesses to the control register
  logic ctl_wr;
  logic ctl_rd;
  assign ctl_wr = wb_ack_o && wb_we_i && wb_adr_i == FEC_OFS_CTRL;
  assign ctl_rd = wb_ack_o && !wb_we_i && wb_adr_i == FEC_OFS_CTRL;
  // high voltage write and a read showing both selects
  logic hv_wr;
  logic both_sel;
  assign hv_wr    = ctl_wr && wb_dat_i[FEC_CTRL_HV];
  assign both_sel = wb_dat_o[FEC_CTRL_WIPE] && wb_dat_o[FEC_CTRL_PGM];
  // a request from idle, sweep excluded since it delays the take
  sequence s_req_start;
    $rose(wb_cyc_i && wb_stb_i) && !pump_on;
  endsequence
  sequence s_ack_late;
    ##2 wb_ack_o;
  endsequence
  sequence s_hv_bare;
    ctl_wr && wb_dat_i[FEC_CTRL_HV] && !wb_dat_i[FEC_CTRL_WIPE] && !wb_dat_i[FEC_CTRL_PGM];
  endsequence
  a_ack_latency: assert property (s_req_start |-> s_ack_late)
    else $error("ack not two edges after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_pump_cause: assert property ($rose(pump_on) |-> $past(hv_wr))
    else $error("pump rose without high voltage write");
  a_pump_drop: assert property (ctl_wr && !wb_dat_i[FEC_CTRL_HV] |=> !pump_on)
    else $error("pump stayed on after clear");
  a_hv_unselected: assert property (s_hv_bare and !pump_on |=> !pump_on[*2])
    else $error("high voltage taken without selection");
  a_sel_interlock: assert property (ctl_rd |-> !both_sel)
    else $error("erase and program both set");
  a_hv_pump_match: assert property (ctl_rd |-> wb_dat_o[FEC_CTRL_HV] == pump_on)
    else $error("pump differs from control bit");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h13 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind fec_top fec_chk #(.PAGE_HOLD(PAGE_HOLD), .MASS_HOLD(MASS_HOLD)) u_chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pump_on(pump_on));

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
  import fec_pkg::*;
  localparam int PH = 50;   // shortened page hold
  localparam int MH = 100;  // shortened mass hold
  logic        sys_clk;
  logic        reset_n;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic        wb_ack;
  logic        pump_on;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat;
  logic [31:0] wb_rd;
  logic [31:0] expq[$];
  logic [15:0] seed;
  logic [31:0] d1;
  logic [31:0] d2;
  int          n_mismatch;
  int          tests_run;
  int          cycles;

  fec_top #(.PAGE_HOLD(PH), .MASS_HOLD(MH)) dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .pump_on(pump_on));

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // pump settles one cycle after the control write, so allow two edges
  task automatic chk_pump(input logic exp);
    repeat (2) @(posedge sys_clk);
    tests_run++;
    if (pump_on !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, pump_on, exp);
    end
  endtask

  task automatic close_out;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // classic cycle: hold everything until ack is sampled, then release
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= 4'hf;
    do @(posedge sys_clk); while (wb_ack !== 1'b1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    expq.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask

  // select, read protect, arming write, setup wait, then high voltage
  task automatic arm(input logic [31:0] c, input logic [31:0] bp);
    wr(FEC_OFS_CTRL, c);
    rd(FEC_OFS_BPR, bp);
    rd(FEC_OFS_CTRL, c);
    wr(FEC_OFS_DATA, 32'h0);
    repeat (SETUP_CYC) @(posedge sys_clk);
    wr(FEC_OFS_CTRL, c | 32'h8);
  endtask

  // read results are matched against the oldest note
  always @(posedge sys_clk) begin
    if (wb_ack === 1'b1 && wb_we === 1'b0 && expq.size() > 0) cmp(wb_rd, expq.pop_front());
  end

  // hang guard, well above the sweep and setup waits
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    reset_n = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h0;
    wb_sel = 4'h0;
    wb_dat = 32'h0;
    n_mismatch = 0;
    tests_run = 0;
    cycles = 0;
    seed = 16'h9556;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(FEC_OFS_CTRL, 32'h0);
    rd(FEC_OFS_ADDR, 32'hc000);
    rd(8'h20, 32'h0);
    chk_pump(1'b0);
    // interlock: a write asking for both keeps the old pair
    wr(FEC_OFS_CTRL, 32'h3);
    rd(FEC_OFS_CTRL, 32'h0);
    wr(FEC_OFS_CTRL, 32'h8);
    rd(FEC_OFS_CTRL, 32'h0);
    wr(FEC_OFS_CTRL, 32'h1);
    wr(FEC_OFS_CTRL, 32'h3);
    rd(FEC_OFS_CTRL, 32'h1);
    wr(FEC_OFS_CTRL, 32'h2);
    wr(FEC_OFS_CTRL, 32'ha);
    rd(FEC_OFS_CTRL, 32'h2);
    rd(FEC_OFS_STAT, 32'h20);
    wr(FEC_OFS_STAT, 32'h20);
    wr(FEC_OFS_CTRL, 32'h0);
    // one protected block must stop a mass erase
    dut.u_mem.cells[14'h3f7e] = 8'hfe;
    arm(32'h6, 32'hfe);
    chk_pump(1'b0);
    wr(FEC_OFS_CTRL, 32'h0);
    dut.u_mem.cells[14'h3f7e] = 8'hff;
    wr(FEC_OFS_ADDR, 32'hff7e);
    arm(32'h6, 32'hff);
    chk_pump(1'b1);
    repeat (MH + 10) @(posedge sys_clk);
    wr(FEC_OFS_CTRL, 32'h8);
    wr(FEC_OFS_CTRL, 32'h0);
    chk_pump(1'b0);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(FEC_OFS_ADDR, 32'hc000 + {19'h0, seed[12:0]});
      rd(FEC_OFS_DATA, 32'hff);
    end
    wr(FEC_OFS_ADDR, 32'hfe00);
    rd(FEC_OFS_DATA, 32'h0);
    wr(FEC_OFS_ADDR, 32'hffdc);
    rd(FEC_OFS_DATA, 32'hff);
    // program one byte on each of two neighbouring pages
    seed = lfsr(seed);
    d1 = {24'h0, seed[7:0]};
    d2 = {25'h0, seed[14:8]};
    wr(FEC_OFS_ADDR, 32'hc040);
    arm(32'h1, 32'hff);
    wr(FEC_OFS_DATA, d1);
    wr(FEC_OFS_ADDR, 32'hc080);
    wr(FEC_OFS_DATA, d2);
    wr(FEC_OFS_CTRL, 32'h8);
    wr(FEC_OFS_CTRL, 32'h0);
    wr(FEC_OFS_ADDR, 32'hc040);
    rd(FEC_OFS_DATA, d1);
    // page erase aimed at the top byte of the first page
    wr(FEC_OFS_ADDR, 32'hc07f);
    arm(32'h2, 32'hff);
    repeat (PH + 10) @(posedge sys_clk);
    wr(FEC_OFS_CTRL, 32'h8);
    wr(FEC_OFS_CTRL, 32'h0);
    wr(FEC_OFS_ADDR, 32'hc040);
    rd(FEC_OFS_DATA, 32'hff);
    wr(FEC_OFS_ADDR, 32'hc080);
    rd(FEC_OFS_DATA, d2);
    rd(FEC_OFS_STAT, 32'h30);
    // the security page refuses a page erase
    wr(FEC_OFS_ADDR, 32'hffc0);
    arm(32'h2, 32'hff);
    chk_pump(1'b0);
    rd(FEC_OFS_CTRL, 32'h2);
    wr(FEC_OFS_CTRL, 32'h0);
    close_out();
  end
endmodule
